// file: common/reset_state_init_pkg.sv
// constants, types and per-register reset tables for the reset-state initialiser
// assumes byte addressing on a 32-bit apb bus, one register per aligned word
//
// Behaviour
// - status holds watchdog-expiry and sleep-entry flags
// - power-on reset clears both status flags
// - pin or dip reset when awake: flags unchanged
// - watchdog reset when awake: expiry flag set
// - watchdog reset asleep: both flags set
// - power-on reset forces program counter zero
// - power-on reset disables all interrupts
// - power-on clears watchdog, counting restarts
// - power-on stops timers, clears timer prescaler
// - power-on makes every port pin input
// - power-on points stack pointer at top
// - program counter low cleared on every reset
// - watchdog reset asleep keeps other registers
// - pin reset asleep gives flags 01
// - period select 111, timer0 control 08
// - clear interrupt controls, counters stay undefined
// - working and table registers: power-on only
// - watchdog asleep clears pc and stack
package reset_state_init_pkg;

	// ***************************************************************
	// register indices (byte address is four times the index)
	// ***************************************************************
	localparam int unsigned NREG_CORE = 19;
	localparam int unsigned NREG_ALL  = 22;
	localparam int unsigned ADDR_W    = 8;

	localparam logic [4:0] IDX_PCL     = 5'h00;
	localparam logic [4:0] IDX_PTR0    = 5'h01;
	localparam logic [4:0] IDX_PTR1    = 5'h02;
	localparam logic [4:0] IDX_BANK    = 5'h03;
	localparam logic [4:0] IDX_WORK    = 5'h04;
	localparam logic [4:0] IDX_TABLE_READ_POINTER    = 5'h05;
	localparam logic [4:0] IDX_TABLE_READ_HIGH_BYTE    = 5'h06;
	localparam logic [4:0] IDX_WATCHDOG_PERIOD_SELECT    = 5'h07;
	localparam logic [4:0] IDX_STATUS  = 5'h08;
	localparam logic [4:0] IDX_INTERRUPT_CONTROL_0   = 5'h09;
	localparam logic [4:0] IDX_INTERRUPT_CONTROL_1   = 5'h0a;
	localparam logic [4:0] IDX_MULTIFUNCTION_IRQ_CONTROL    = 5'h0b;
	localparam logic [4:0] IDX_TIMER0_COUNT    = 5'h0c;
	localparam logic [4:0] IDX_TIMER0_CONTROL   = 5'h0d;
	localparam logic [4:0] IDX_TIMER1_COUNT    = 5'h0e;
	localparam logic [4:0] IDX_TIMER1_CONTROL   = 5'h0f;
	localparam logic [4:0] IDX_TIMER2_COUNT_LOW   = 5'h10;
	localparam logic [4:0] IDX_TIMER2_COUNT_HIGH   = 5'h11;
	localparam logic [4:0] IDX_TIMER2_CONTROL   = 5'h12;
	localparam logic [4:0] IDX_CAUSE   = 5'h13;
	localparam logic [4:0] IDX_MASK    = 5'h14;
	localparam logic [4:0] IDX_CONTROL = 5'h15;

	// ***************************************************************
	// field positions and reset values
	// ***************************************************************
	localparam int unsigned STATUS_EXPIRY_BIT = 5;
	localparam int unsigned STATUS_SLEEP_BIT  = 4;
	localparam logic [7:0]  STATUS_SW_MASK    = 8'h0f;

	localparam int unsigned CAUSE_W          = 4;
	localparam int unsigned CAUSE_PIN_BIT    = 0;
	localparam int unsigned CAUSE_DIP_BIT    = 1;
	localparam int unsigned CAUSE_WDT_BIT    = 2;
	localparam int unsigned CAUSE_WATCHDOG_PERIOD_SELECT_BIT   = 3;
	localparam logic [3:0]  MASK_RESET       = 4'h0;

	localparam int unsigned CTRL_DIP_EN_BIT  = 0;
	localparam int unsigned CTRL_WDT_EN_BIT  = 1;
	localparam int unsigned CTRL_CLASS_LSB   = 4;
	localparam logic [1:0]  CONTROL_RESET    = 2'h3;

	typedef enum logic [2:0] {
		CLS_NONE,
		CLS_PIN_AWAKE,
		CLS_PIN_ASLEEP,
		CLS_WDT_AWAKE,
		CLS_WDT_ASLEEP
	} reset_class_type;

	// one-cycle actions handed to the core, timers, ports and watchdog
	typedef struct packed {
		logic pc_clear;
		logic stack_top;
		logic irq_off;
		logic wdt_clear;
		logic timers_off;
		logic prescaler_clear;
		logic ports_input;
	} restart_type;

	// implemented bits of each core register
	function automatic logic [7:0] impl_mask(input logic [4:0] idx);
		case (idx)
			IDX_BANK:   impl_mask = 8'h1f;
			IDX_WATCHDOG_PERIOD_SELECT:   impl_mask = 8'h07;
			IDX_STATUS: impl_mask = 8'h3f;
			IDX_INTERRUPT_CONTROL_0:  impl_mask = 8'h7f;
			IDX_INTERRUPT_CONTROL_1:  impl_mask = 8'h77;
			IDX_MULTIFUNCTION_IRQ_CONTROL:   impl_mask = 8'h77;
			IDX_TIMER1_CONTROL:  impl_mask = 8'hf8;
			IDX_TIMER2_CONTROL:  impl_mask = 8'hf8;
			default:    impl_mask = 8'hff;
		endcase
	endfunction

	// value loaded by a full reset; undefined registers take zero at power-on
	function automatic logic [7:0] load_value(input logic [4:0] idx);
		case (idx)
			IDX_WATCHDOG_PERIOD_SELECT:  load_value = 8'h07;
			IDX_TIMER0_CONTROL: load_value = 8'h08;
			IDX_TIMER1_CONTROL: load_value = 8'h08;
			IDX_TIMER2_CONTROL: load_value = 8'h08;
			default:   load_value = 8'h00;
		endcase
	endfunction

	// registers given a defined value by every full reset class
	function automatic logic reloads(input logic [4:0] idx);
		case (idx)
			IDX_PCL, IDX_BANK, IDX_WATCHDOG_PERIOD_SELECT, IDX_INTERRUPT_CONTROL_0, IDX_INTERRUPT_CONTROL_1, IDX_MULTIFUNCTION_IRQ_CONTROL,
			IDX_TIMER0_CONTROL, IDX_TIMER1_CONTROL, IDX_TIMER2_CONTROL: reloads = 1'b1;
			default:                         reloads = 1'b0;
		endcase
	endfunction

endpackage

// file: hw/reset_state_init.sv
// reset-state initialiser: classifies each reset and loads the core registers
// assumes watchdog, sleep and flag inputs come from logic on clk; the reset pin
// and supply monitor are asynchronous; rst_n low is the power-on reset
`timescale 1ns/1ps

module reset_state_init (
	// clock and power-on reset
	input  wire logic                                          clk,
	input  wire logic                                          rst_n,
	// reset sources
	input  wire logic                                          external_clear_pin_n,
	input  wire logic                                          supply_dip_reset,
	input  wire logic                                          watchdog_expiry,
	// core mode and flag events
	input  wire logic                                          sleep_mode,
	input  wire logic                                          sleep_enter,
	input  wire logic                                          flag_clear,
	// apb slave
	input  wire logic                                          psel,
	input  wire logic                                          penable,
	input  wire logic                                          pwrite,
	input  wire logic [reset_state_init_pkg::ADDR_W-1:0]       paddr,
	input  wire logic [31:0]                                   pwdata,
	output logic      [31:0]                                   prdata,
	output logic                                               pready,
	output logic                                               pslverr,
	// core register image and restart actions
	output logic      [reset_state_init_pkg::NREG_CORE-1:0][7:0] core_regs,
	output reset_state_init_pkg::restart_type                  restart,
	output logic                                               irq
);

	// ***************************************************************
	// declarations
	// ***************************************************************
	logic [2:0]                                      pin_sync_q;
	logic [2:0]                                      dip_sync_q;
	logic                                            pin_level_q;
	logic                                            dip_level_q;
	logic                                            pin_fall;
	logic                                            dip_rise;
	reset_state_init_pkg::reset_class_type           cls;
	reset_state_init_pkg::reset_class_type           last_class_q;
	logic [reset_state_init_pkg::NREG_CORE-1:0][7:0] regs_q;
	logic [reset_state_init_pkg::CAUSE_W-1:0]        cause_q;
	logic [reset_state_init_pkg::CAUSE_W-1:0]        cause_d;
	logic [reset_state_init_pkg::CAUSE_W-1:0]        cause_set;
	logic [reset_state_init_pkg::CAUSE_W-1:0]        mask_q;
	logic [reset_state_init_pkg::CAUSE_W-1:0]        mask_d;
	logic [1:0]                                      control_q;
	logic [4:0]                                      idx;
	logic                                            addr_ok;
	logic                                            setup;
	logic                                            access;
	logic                                            wr_en;
	logic                                            rd_en;
	logic [31:0]                                     rdata;
	logic                                            dip_en;
	logic                                            wdt_en;

	assign dip_en = control_q[reset_state_init_pkg::CTRL_DIP_EN_BIT];
	assign wdt_en = control_q[reset_state_init_pkg::CTRL_WDT_EN_BIT];

	// ***************************************************************
	// asynchronous source synchronisers
	// ***************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_sync_q  <= 3'h7;
			pin_level_q <= 1'b1;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], external_clear_pin_n};
			if (pin_sync_q[1] == pin_sync_q[2]) begin
				pin_level_q <= pin_sync_q[2];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dip_sync_q  <= 3'h0;
			dip_level_q <= 1'b0;
		end else begin
			dip_sync_q <= {dip_sync_q[1:0], supply_dip_reset};
			if (dip_sync_q[1] == dip_sync_q[2]) begin
				dip_level_q <= dip_sync_q[2];
			end
		end
	end

	// a change counts once second and third stages agree
	assign pin_fall = pin_level_q & ~pin_sync_q[1] & ~pin_sync_q[2];
	assign dip_rise = ~dip_level_q & dip_sync_q[1] & dip_sync_q[2];

	// ***************************************************************
	// reset classification
	// ***************************************************************
	// pin or dip wins over a watchdog expiry in the same cycle
	always_comb begin
		cls = reset_state_init_pkg::CLS_NONE;
		if (pin_fall || (dip_rise && dip_en)) begin
			cls = sleep_mode ? reset_state_init_pkg::CLS_PIN_ASLEEP : reset_state_init_pkg::CLS_PIN_AWAKE;
		end else if (watchdog_expiry && wdt_en) begin
			cls = sleep_mode ? reset_state_init_pkg::CLS_WDT_ASLEEP : reset_state_init_pkg::CLS_WDT_AWAKE;
		end
	end

	always_comb begin
		cause_set = '0;
		cause_set[reset_state_init_pkg::CAUSE_PIN_BIT]  = pin_fall;
		cause_set[reset_state_init_pkg::CAUSE_DIP_BIT]  = dip_rise & dip_en;
		cause_set[reset_state_init_pkg::CAUSE_WDT_BIT]  = (cls == reset_state_init_pkg::CLS_WDT_AWAKE);
		cause_set[reset_state_init_pkg::CAUSE_WATCHDOG_PERIOD_SELECT_BIT] = (cls == reset_state_init_pkg::CLS_WDT_ASLEEP);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			last_class_q <= reset_state_init_pkg::CLS_NONE;
		end else if (cls != reset_state_init_pkg::CLS_NONE) begin
			last_class_q <= cls;
		end
	end

	// ***************************************************************
	// apb decode
	// ***************************************************************
	assign idx     = paddr[6:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0)
		&& (idx <= reset_state_init_pkg::IDX_CONTROL);
	assign setup   = psel & ~penable;
	assign access  = psel & penable & pready;
	assign wr_en   = access & pwrite & addr_ok;
	assign rd_en   = access & ~pwrite & addr_ok;

	always_comb begin
		rdata = 32'h0;
		if (idx < reset_state_init_pkg::IDX_CAUSE) begin
			rdata[7:0] = regs_q[idx];
		end else if (idx == reset_state_init_pkg::IDX_CAUSE) begin
			rdata[reset_state_init_pkg::CAUSE_W-1:0] = cause_q;
		end else if (idx == reset_state_init_pkg::IDX_MASK) begin
			rdata[reset_state_init_pkg::CAUSE_W-1:0] = mask_q;
		end else begin
			rdata[1:0] = control_q;
			rdata[reset_state_init_pkg::CTRL_CLASS_LSB +: 3] = last_class_q;
		end
	end

	// no wait state: data captured in setup, pready raised in access
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= ~addr_ok;
			prdata  <= (addr_ok && !pwrite) ? rdata : 32'h0;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
	end

	// ***************************************************************
	// core register file
	// ***************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < reset_state_init_pkg::NREG_CORE; i++) begin
				regs_q[i] <= reset_state_init_pkg::load_value(5'(i));
			end
		end else begin
			if (wr_en && idx < reset_state_init_pkg::IDX_CAUSE) begin
				if (idx == reset_state_init_pkg::IDX_STATUS) begin
					regs_q[idx] <= (regs_q[idx] & ~reset_state_init_pkg::STATUS_SW_MASK)
						| (pwdata[7:0] & reset_state_init_pkg::STATUS_SW_MASK);
				end else begin
					regs_q[idx] <= pwdata[7:0] & reset_state_init_pkg::impl_mask(idx);
				end
			end
			if (flag_clear) begin
				regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_EXPIRY_BIT] <= 1'b0;
				regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_SLEEP_BIT]  <= 1'b0;
			end
			if (sleep_enter) begin
				regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_SLEEP_BIT] <= 1'b1;
			end
			case (cls)
				reset_state_init_pkg::CLS_PIN_AWAKE,
				reset_state_init_pkg::CLS_PIN_ASLEEP,
				reset_state_init_pkg::CLS_WDT_AWAKE: begin
					for (int i = 0; i < reset_state_init_pkg::NREG_CORE; i++) begin
						if (reset_state_init_pkg::reloads(5'(i))) begin
							regs_q[i] <= reset_state_init_pkg::load_value(5'(i));
						end
					end
					if (cls == reset_state_init_pkg::CLS_PIN_ASLEEP) begin
						regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_EXPIRY_BIT] <= 1'b0;
						regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_SLEEP_BIT]  <= 1'b1;
					end else if (cls == reset_state_init_pkg::CLS_WDT_AWAKE) begin
						regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_EXPIRY_BIT] <= 1'b1;
						if (flag_clear && !sleep_enter) begin
							regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_SLEEP_BIT] <=
								regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_SLEEP_BIT];
						end
					end else begin
						regs_q[reset_state_init_pkg::IDX_STATUS][5:4] <= regs_q[reset_state_init_pkg::IDX_STATUS][5:4];
					end
				end
				reset_state_init_pkg::CLS_WDT_ASLEEP: begin
					regs_q[reset_state_init_pkg::IDX_PCL] <= 8'h00;
					regs_q[reset_state_init_pkg::IDX_STATUS] <= regs_q[reset_state_init_pkg::IDX_STATUS];
					regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_EXPIRY_BIT] <= 1'b1;
					regs_q[reset_state_init_pkg::IDX_STATUS][reset_state_init_pkg::STATUS_SLEEP_BIT]  <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	assign core_regs = regs_q;

	// ***************************************************************
	// restart actions
	// ***************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			restart <= '1;
		end else begin
			restart <= '0;
			case (cls)
				reset_state_init_pkg::CLS_PIN_AWAKE,
				reset_state_init_pkg::CLS_PIN_ASLEEP,
				reset_state_init_pkg::CLS_WDT_AWAKE: begin
					restart <= '1;
				end
				reset_state_init_pkg::CLS_WDT_ASLEEP: begin
					restart.pc_clear  <= 1'b1;
					restart.stack_top <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// ***************************************************************
	// cause, mask, control and interrupt
	// ***************************************************************
	// set wins over the read clear
	always_comb begin
		cause_d = cause_q;
		if (rd_en && idx == reset_state_init_pkg::IDX_CAUSE) begin
			cause_d = '0;
		end
		cause_d = cause_d | cause_set;
		mask_d = mask_q;
		if (wr_en && idx == reset_state_init_pkg::IDX_MASK) begin
			mask_d = pwdata[reset_state_init_pkg::CAUSE_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cause_q <= '0;
			mask_q  <= reset_state_init_pkg::MASK_RESET;
			irq     <= 1'b0;
		end else begin
			cause_q <= cause_d;
			mask_q  <= mask_d;
			irq     <= |(cause_d & mask_d);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control_q <= reset_state_init_pkg::CONTROL_RESET;
		end else if (wr_en && idx == reset_state_init_pkg::IDX_CONTROL) begin
			control_q <= pwdata[1:0];
		end
	end

endmodule

// file: tb/reset_state_init_monitor.sv
// port checker for the reset-state initialiser
// assumes the watchdog enable stays set and events never coincide
`timescale 1ns/1ps

module reset_state_init_monitor (
	// clock and reset
	input wire logic                                            clk,
	input wire logic                                            rst_n,
	// watched inputs
	input wire logic                                            watchdog_expiry,
	input wire logic                                            sleep_mode,
	input wire logic                                            sleep_enter,
	input wire logic                                            flag_clear,
	input wire logic                                            psel,
	input wire logic                                            penable,
	input wire logic [reset_state_init_pkg::ADDR_W-1:0]         paddr,
	// watched outputs
	input wire logic                                            pready,
	input wire logic                                            pslverr,
	input wire logic [reset_state_init_pkg::NREG_CORE-1:0][7:0] core_regs,
	input wire reset_state_init_pkg::restart_type               restart
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wdt_awake;
		watchdog_expiry && !sleep_mode && !sleep_enter && !flag_clear;
	endsequence
	sequence s_wdt_asleep;
		watchdog_expiry && sleep_mode;
	endsequence

	property p_por;
		disable iff (1'b0) !rst_n |=> core_regs[8][5:4] == 2'b00 && core_regs[0] == 8'h00 && restart == 7'h7f;
	endproperty
	property p_por_load;
		disable iff (1'b0) !rst_n |=> core_regs[7] == 8'h07 && core_regs[13] == 8'h08 && core_regs[9] == 8'h00;
	endproperty
	property p_wdt_awake;
		s_wdt_awake |=> core_regs[8][5] && core_regs[8][4] == $past(core_regs[8][4]) && core_regs[7] == 8'h07;
	endproperty
	property p_wdt_asleep;
		s_wdt_asleep |=> core_regs[8][5:4] == 2'b11;
	endproperty
	property p_asleep_keep;
		s_wdt_asleep |=> $stable(core_regs[7]) && $stable(core_regs[13]) && $stable(core_regs[9]);
	endproperty
	property p_pc_clear;
		watchdog_expiry |=> core_regs[0] == 8'h00 && restart.pc_clear && restart.stack_top;
	endproperty
	property p_apb_answer;
		s_setup |=> pready ##1 !pready;
	endproperty
	property p_apb_err;
		s_setup ##0 paddr >= 8'h58 |=> pslverr && pready;
	endproperty
	property p_sleep_flag;
		sleep_enter |=> core_regs[8][4];
	endproperty
	property p_flag_clear;
		flag_clear && !sleep_enter && !watchdog_expiry |=> core_regs[8][5:4] == 2'b00;
	endproperty

	a_por: assert property (p_por) else $error("power-on state wrong");
	a_por_load: assert property (p_por_load) else $error("power-on loads wrong");
	a_wdt_awake: assert property (p_wdt_awake) else $error("awake watchdog reset wrong");
	a_wdt_asleep: assert property (p_wdt_asleep) else $error("asleep watchdog flags wrong");
	a_asleep_keep: assert property (p_asleep_keep) else $error("asleep watchdog changed a register");
	a_pc_clear: assert property (p_pc_clear) else $error("pc or stack not cleared");
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");
	a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused");
	a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag not set");
	a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");
endmodule

bind reset_state_init reset_state_init_monitor u_mon (.clk(clk), .rst_n(rst_n),
	.watchdog_expiry(watchdog_expiry), .sleep_mode(sleep_mode), .sleep_enter(sleep_enter),
	.flag_clear(flag_clear), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .core_regs(core_regs), .restart(restart));

// file: tb/reset_source_model.sv
// reset pin, supply monitor and watchdog standing outside the block
// assumes go is a one-cycle request; kind 0 pin, 1 dip, 2 watchdog
`timescale 1ns/1ps

module reset_source_model (
	// control from bench
	input wire logic       clk,
	input wire logic [1:0] kind,
	input wire logic       go,
	// reset sources
	output logic           pin_n,
	output logic           dip,
	output logic           wdt
);
	initial begin
		pin_n = 1'b1;
		dip = 1'b0;
		wdt = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				case (kind)
					// pin and dip move off the clock, as real async sources
					2'd0: begin
						#7 pin_n = 1'b0;
						repeat (4) @(posedge clk);
						#7 pin_n = 1'b1;
					end
					2'd1: begin
						#7 dip = 1'b1;
						repeat (4) @(posedge clk);
						#7 dip = 1'b0;
					end
					default: begin
						wdt <= 1'b1;
						@(posedge clk);
						wdt <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule

// file: tb/reset_state_init_tb.sv
// self-checking bench for the reset-state initialiser
// assumes reset_source_model supplies the reset events
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end

module reset_state_init_tb;
	logic                              clk;
	logic                              rst_n;
	logic                              sleep_mode;
	logic                              sleep_enter;
	logic                              flag_clear;
	logic                              psel;
	logic                              penable;
	logic                              pwrite;
	logic [7:0]                        paddr;
	logic [31:0]                       pwdata;
	logic [31:0]                       prdata;
	logic                              pready;
	logic                              pslverr;
	logic [18:0][7:0]                  core_regs;
	reset_state_init_pkg::restart_type restart;
	logic                              irq;
	logic                              pin_n;
	logic                              dip;
	logic                              wdt;
	logic [1:0]                        kind;
	logic                              go;
	logic [31:0]                       d;
	logic [31:0]                       rdat;
	logic                              rerr;
	int                                mismatches;
	int                                total_checks;
	int                                m[19];
	int msk[19] = '{255, 255, 255, 31, 255, 255, 255, 7, 15, 127, 119, 119, 255, 255, 255, 248, 255, 255, 248};
	int rl[9] = '{0, 3, 7, 9, 10, 11, 13, 15, 18};

	reset_state_init DUT (.clk(clk), .rst_n(rst_n), .external_clear_pin_n(pin_n), .supply_dip_reset(dip),
		.watchdog_expiry(wdt), .sleep_mode(sleep_mode), .sleep_enter(sleep_enter), .flag_clear(flag_clear),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core_regs(core_regs), .restart(restart), .irq(irq));
	reset_source_model partner (.clk(clk), .kind(kind), .go(go), .pin_n(pin_n), .dip(dip), .wdt(wdt));

	// ***************************************************************
	// tasks
	// ***************************************************************
	task automatic summarize();
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			summarize();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("prdata", e, rdat)
	endtask

	task automatic por();
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		#1 `CHK("restart_por", 7'h7f, restart)
		@(posedge clk);
		rst_n <= 1'b1;
		foreach (m[i]) m[i] = (i == 7) ? 7 : (i == 13 || i == 15 || i == 18) ? 8 : 0;
		@(posedge clk);
		#1 foreach (m[i]) `CHK("core_regs", m[i][7:0], core_regs[i])
	endtask

	task automatic fire(input logic [1:0] k, input logic s, input logic mb);
		int n;
		int c;
		sleep_mode <= s;
		kind <= k;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (restart.pc_clear !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			summarize();
		end
		m[0] = 0;
		if (k == 2'd2 && s)
			m[8] |= 8'h30;
		else begin
			foreach (rl[j]) m[rl[j]] = (rl[j] == 7) ? 7 : (rl[j] > 12) ? 8 : 0;
			if (k == 2'd2)
				m[8] |= 8'h20;
			else if (s)
				m[8] = (m[8] & 8'h0f) | 8'h10;
		end
		c = (k == 2'd2) ? (s ? 4 : 3) : (s ? 2 : 1);
		foreach (m[i]) `CHK("core_regs", m[i][7:0], core_regs[i])
		`CHK("pc_stack", 2'b11, {restart.pc_clear, restart.stack_top})
		`CHK("restart", (k == 2'd2 && s) ? 7'h60 : 7'h7f, restart)
		@(posedge clk);
		#1 `CHK("restart_end", 7'h00, restart)
		`CHK("irq", mb, irq)
		rd(8'h54, 32'h3 | (c << 4));
		rd(8'h4c, 32'h1 << ((k == 2'd2) ? (s ? 3 : 2) : k));
		rd(8'h4c, 32'h0);
		`CHK("irq_clr", 1'b0, irq)
	endtask

	// ***************************************************************
	// clock, timeout and main sequence
	// ***************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end

	initial begin
		{rst_n, sleep_mode, sleep_enter, flag_clear, psel, penable, pwrite, go} = 8'h00;
		{paddr, pwdata, kind, mismatches, total_checks} = '0;
		void'($urandom(43218));
		por();
		rd(8'h54, 32'h3);
		rd(8'h50, 32'h0);
		apb(1'b0, 8'h58, 32'h0);
		`CHK("pslverr", 1'b1, rerr)
		`CHK("err_data", 32'h0, rdat)
		for (int t = 0; t < 12; t++) begin
			for (int i = 0; i < 19; i++) begin
				d = $urandom;
				apb(1'b1, 8'(i * 4), d);
				m[i] = (i == 8) ? (m[8] & 8'h30) | (d & 8'h0f) : d & msk[i];
			end
			if (t % 3 == 0) begin
				flag_clear <= 1'b1;
				@(posedge clk);
				flag_clear <= 1'b0;
				m[8] &= 8'h0f;
			end
			if (d[0]) begin
				sleep_enter <= 1'b1;
				@(posedge clk);
				sleep_enter <= 1'b0;
				m[8] |= 8'h10;
			end
			apb(1'b1, 8'h50, (t < 6) ? 32'hf : 32'h0);
			rd(8'h20, 32'(m[8]));
			fire(2'(t % 3), 1'((t / 3) % 2), t < 6);
		end
		apb(1'b0, 8'h21, 32'h0);
		`CHK("unaligned_err", 1'b1, rerr)
		`CHK("unaligned_data", 32'h0, rdat)
		// dip source disabled: its event must leave everything alone
		apb(1'b1, 8'h54, 32'h2);
		rd(8'h54, 32'h42);
		kind <= 2'd1;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (10) @(posedge clk);
		#1 foreach (m[i]) `CHK("core_regs_refused", m[i][7:0], core_regs[i])
		rd(8'h4c, 32'h0);
		por();
		summarize();
	end
endmodule
